// file: verilog/two_wire_master_dma.v
/*
  Single-master two-wire bus controller with memory access channels.
  Assumes task inputs are one-cycle pulses on mclk_i, the memory read
  port answers each request with one ack, and SCL/SDA have pull-ups.
*/
`timescale 1ns/1ps
`include "two_wire_master_dma_regs.vh"

module two_wire_master_dma #(
  parameter AW = 32,
  parameter CW = 16
) (
  input  wire          mclk_i,           // 250 MHz clock
  input  wire          reset_n_i,        // Async reset, active low
  input  wire          task_begin_write_i, // Start write pulse
  input  wire          task_begin_read_i,  // Start read pulse
  input  wire          task_stop_i,      // Stop pulse
  input  wire          task_suspend_i,   // Suspend pulse
  input  wire          task_resume_i,    // Resume pulse
  input  wire [6:0]    slave_addr_i,     // Target address
  input  wire [1:0]    rate_sel_i,       // Bus rate code
  input  wire [AW-1:0] tx_buffer_pointer_i, // Next tx base
  input  wire [CW-1:0] tx_max_count_i,   // Next tx length
  input  wire [AW-1:0] rx_buffer_pointer_i, // Next rx base
  input  wire [CW-1:0] rx_max_count_i,   // Next rx length
  input  wire [`EVT_COUNT-1:0] evt_clear_i,  // Flag clear
  input  wire [`EVT_COUNT-1:0] evt_inten_i,  // Flag enable
  output wire [`EVT_COUNT-1:0] evt_pulse_o,  // Event pulses
  output wire [`EVT_COUNT-1:0] evt_flags_o,  // Sticky flags
  output wire          irq_o,            // Interrupt request
  output wire          tx_rd_req_o,      // Memory read request
  output wire [AW-1:0] tx_rd_addr_o,     // Memory read address
  input  wire          tx_rd_ack_i,      // Read data valid
  input  wire [7:0]    tx_rd_data_i,     // Read data
  output wire          rx_wr_valid_o,    // Memory write request
  output wire [AW-1:0] rx_wr_addr_o,     // Memory write address
  output wire [7:0]    rx_wr_data_o,     // Memory write data
  input  wire          rx_wr_ready_i,    // Write accepted
  input  wire          scl_i,            // SCL pin level
  output wire          scl_o,            // SCL out, always low
  output wire          scl_oe_o,         // SCL pull low
  input  wire          sda_i,            // SDA pin level
  output wire          sda_o,            // SDA out, always low
  output wire          sda_oe_o,         // SDA pull low
  output wire          busy_o            // Not stopped
);

  // -------------------------------------------------------------------
  // States
  // -------------------------------------------------------------------
  localparam [9:0] S_IDLE  = 10'h001;
  localparam [9:0] S_START = 10'h002;
  localparam [9:0] S_ADDR  = 10'h004;
  localparam [9:0] S_BOUND = 10'h008;
  localparam [9:0] S_FETCH = 10'h010;
  localparam [9:0] S_XFER  = 10'h020;
  localparam [9:0] S_HOLD  = 10'h040;
  localparam [9:0] S_SUSP  = 10'h080;
  localparam [9:0] S_STOP  = 10'h100;
  localparam [9:0] S_DRAIN = 10'h200;

  localparam integer Q100 = `QUARTER_CYC(`BIT_100K_NS);
  localparam integer Q250 = `QUARTER_CYC(`BIT_250K_NS);
  localparam integer Q400 = `QUARTER_CYC(`BIT_400K_NS);

  reg  [9:0]    st_reg;
  reg           dir_reg;
  reg  [3:0]    bitn_reg;
  reg  [7:0]    sh_reg;
  reg  [CW-1:0] cnt_reg;
  reg  [CW-1:0] max_reg;
  reg  [AW-1:0] ptr_reg;
  reg           end_reg;
  reg           start_pend_reg;
  reg           start_dir_reg;
  reg           stop_pend_reg;
  reg           susp_pend_reg;
  reg           issued_reg;
  reg           go_reg;
  reg           go_a_reg;
  reg           go_b_reg;
  reg           txreq_reg;
  reg  [AW-1:0] txaddr_reg;
  reg           push_reg;
  reg  [AW+7:0] push_data_reg;
  reg  [`EVT_COUNT-1:0] evt_reg;
  reg  [`EVT_COUNT-1:0] flags_reg;
  reg  [9:0]    qcnt_reg;
  reg  [1:0]    ph_reg;
  reg           busy_reg;
  reg           a_reg;
  reg           b_reg;
  reg           samp_reg;
  reg           done_reg;
  reg           keep_reg;
  reg           scl_oe_reg;
  reg           sda_oe_reg;
  reg  [9:0]    qtarget;
  wire          scl_s;
  wire          sda_s;
  wire          fifo_ready;
  wire          fifo_empty;
  wire [AW+7:0] fifo_out;
  wire          active;
  wire          last_rx;
  wire [CW-1:0] cnt_inc;

  assign active  = |(st_reg & (S_START | S_ADDR | S_FETCH | S_XFER));
  assign cnt_inc = cnt_reg + 1'b1;
  assign last_rx = (cnt_inc == max_reg);

  // -------------------------------------------------------------------
  // Pin inputs and receive buffer
  // -------------------------------------------------------------------
  pin_sync #(.INIT(`LINE_IDLE)) u_scl_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .async_i   (scl_i),
    .sync_o    (scl_s)
  );

  pin_sync #(.INIT(`LINE_IDLE)) u_sda_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .async_i   (sda_i),
    .sync_o    (sda_s)
  );

  // Address travels with each byte so a chained read cannot misplace it
  sync_fifo #(.W(AW+8), .DEPTH(16), .PW(4)) u_rx_fifo (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push_reg),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_data_reg),
    .out_valid_o (rx_wr_valid_o),
    .out_ready_i (rx_wr_ready_i),
    .out_data_o  (fifo_out),
    .empty_o     (fifo_empty)
  );

  // -------------------------------------------------------------------
  // Bit engine: quarters 0,1 SCL low, 2,3 released; sample end of 2
  // -------------------------------------------------------------------
  always @* begin
    case (rate_sel_i)
      `RATE_250K: qtarget = Q250[9:0];
      `RATE_400K: qtarget = Q400[9:0];
      default:    qtarget = Q100[9:0];
    endcase
  end

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      qcnt_reg <= 10'h000;
      ph_reg   <= 2'h0;
      busy_reg <= 1'b0;
      a_reg    <= `LINE_IDLE;
      b_reg    <= `LINE_IDLE;
      samp_reg <= `LINE_IDLE;
      done_reg <= 1'b0;
      keep_reg <= `LINE_IDLE;
    end else begin
      done_reg <= 1'b0;
      if (go_reg) begin
        busy_reg <= 1'b1;
        ph_reg   <= 2'h0;
        qcnt_reg <= 10'h000;
        a_reg    <= go_a_reg;
        b_reg    <= go_b_reg;
      end else if (busy_reg) begin
        if (ph_reg == 2'h2 && !scl_s) begin
          qcnt_reg <= 10'h000;
        end else if (qcnt_reg == qtarget - 10'h001) begin
          qcnt_reg <= 10'h000;
          ph_reg   <= ph_reg + 2'h1;
          if (ph_reg == 2'h2)
            samp_reg <= sda_s;
          if (ph_reg == 2'h3) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            keep_reg <= b_reg;
          end
        end else begin
          qcnt_reg <= qcnt_reg + 10'h001;
        end
      end
    end
  end

  // Open-drain drive; SDA keeps its level in quarter 0 so it never
  // moves in the same cycle as the falling SCL edge
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      if (busy_reg)
        scl_oe_reg <= ~ph_reg[1];
      else
        scl_oe_reg <= ~(st_reg[0] | st_reg[9]);
      if (busy_reg && ph_reg == 2'h3)
        sda_oe_reg <= ~b_reg;
      else if (busy_reg && ph_reg != 2'h0)
        sda_oe_reg <= ~a_reg;
      else
        sda_oe_reg <= ~keep_reg;
    end
  end

  // -------------------------------------------------------------------
  // Sequencer; sole master, so no arbitration is watched
  // -------------------------------------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg         <= S_IDLE;
      dir_reg        <= `DIR_WRITE;
      bitn_reg       <= 4'h0;
      sh_reg         <= 8'h00;
      cnt_reg        <= {CW{1'b0}};
      max_reg        <= {CW{1'b0}};
      ptr_reg        <= {AW{1'b0}};
      end_reg        <= 1'b0;
      start_pend_reg <= 1'b0;
      start_dir_reg  <= `DIR_WRITE;
      stop_pend_reg  <= 1'b0;
      susp_pend_reg  <= 1'b0;
      issued_reg     <= 1'b0;
      go_reg         <= 1'b0;
      go_a_reg       <= `LINE_IDLE;
      go_b_reg       <= `LINE_IDLE;
      txreq_reg      <= 1'b0;
      txaddr_reg     <= {AW{1'b0}};
      push_reg       <= 1'b0;
      push_data_reg  <= {(AW+8){1'b0}};
      evt_reg        <= `EVT_RESET;
    end else begin
      go_reg  <= 1'b0;
      evt_reg <= `EVT_RESET;
      if (done_reg)
        issued_reg <= 1'b0;
      // Task capture
      if (task_begin_write_i | task_begin_read_i) begin
        start_pend_reg <= 1'b1;
        start_dir_reg  <= task_begin_read_i;
      end
      if (task_stop_i && !st_reg[7])
        stop_pend_reg <= 1'b1;
      if (task_suspend_i && active)
        susp_pend_reg <= 1'b1;
      if (push_reg && fifo_ready)
        push_reg <= 1'b0;
      if (txreq_reg && tx_rd_ack_i)
        txreq_reg <= 1'b0;
      case (st_reg)
        S_IDLE: begin
          if (start_pend_reg)
            st_reg <= S_START;
          else if (stop_pend_reg)
            st_reg <= S_DRAIN;
        end
        S_START: begin
          if (!busy_reg && !issued_reg && !go_reg) begin
            issued_reg     <= 1'b1;
            go_reg         <= 1'b1;
            go_a_reg       <= 1'b1;
            go_b_reg       <= 1'b0;
            start_pend_reg <= 1'b0;
            dir_reg        <= start_dir_reg;
            cnt_reg        <= {CW{1'b0}};
            end_reg        <= 1'b0;
            // Working copies free the inputs for the next setup
            if (start_dir_reg) begin
              ptr_reg <= rx_buffer_pointer_i;
              max_reg <= rx_max_count_i;
              evt_reg[`EVT_RX_STARTED] <= 1'b1;
            end else begin
              ptr_reg <= tx_buffer_pointer_i;
              max_reg <= tx_max_count_i;
              evt_reg[`EVT_TX_STARTED] <= 1'b1;
            end
          end else if (done_reg) begin
            st_reg   <= S_ADDR;
            bitn_reg <= 4'h0;
            sh_reg   <= {slave_addr_i, dir_reg};
          end
        end
        S_ADDR: begin
          if (!busy_reg && !issued_reg && !go_reg) begin
            issued_reg <= 1'b1;
            go_reg     <= 1'b1;
            go_a_reg   <= bitn_reg[3] ? `LINE_IDLE : sh_reg[7];
            go_b_reg   <= bitn_reg[3] ? `LINE_IDLE : sh_reg[7];
          end else if (done_reg) begin
            sh_reg   <= {sh_reg[6:0], 1'b0};
            bitn_reg <= bitn_reg + 4'h1;
            if (bitn_reg[3]) begin
              bitn_reg <= 4'h0;
              st_reg   <= S_BOUND;
              if (samp_reg == `BIT_NACK) begin
                evt_reg[`EVT_ERROR] <= 1'b1;
                end_reg <= 1'b1;
              end else if (max_reg == {CW{1'b0}}) begin
                end_reg <= 1'b1;
              end else if (dir_reg && max_reg == {{(CW-1){1'b0}}, 1'b1}) begin
                evt_reg[`EVT_FINAL_RX] <= 1'b1;
              end
            end
          end
        end
        S_BOUND: begin
          // Byte boundary: restart, stop, suspend or carry on
          if (start_pend_reg) begin
            st_reg <= S_START;
          end else if (stop_pend_reg) begin
            st_reg        <= S_STOP;
            stop_pend_reg <= 1'b0;
          end else if (susp_pend_reg) begin
            st_reg        <= S_SUSP;
            susp_pend_reg <= 1'b0;
            evt_reg[`EVT_SUSPENDED] <= 1'b1;
          end else if (end_reg) begin
            st_reg <= S_HOLD;
          end else if (dir_reg == `DIR_WRITE) begin
            st_reg     <= S_FETCH;
            txreq_reg  <= 1'b1;
            txaddr_reg <= ptr_reg + {{(AW-CW){1'b0}}, cnt_reg};
          end else begin
            st_reg <= S_XFER;
          end
        end
        S_FETCH: begin
          // SCL stays low while memory answers
          if (txreq_reg && tx_rd_ack_i) begin
            sh_reg <= tx_rd_data_i;
            st_reg <= S_XFER;
            if (last_rx)
              evt_reg[`EVT_FINAL_TX] <= 1'b1;
          end
        end
        S_XFER: begin
          if (!busy_reg && !issued_reg && !go_reg &&
              !(push_reg && bitn_reg[3])) begin
            issued_reg <= 1'b1;
            go_reg     <= 1'b1;
            if (dir_reg == `DIR_WRITE) begin
              go_a_reg <= bitn_reg[3] ? `LINE_IDLE : sh_reg[7];
              go_b_reg <= bitn_reg[3] ? `LINE_IDLE : sh_reg[7];
            end else begin
              // Nack only the last byte
              go_a_reg <= bitn_reg[3] ? last_rx : `LINE_IDLE;
              go_b_reg <= bitn_reg[3] ? last_rx : `LINE_IDLE;
            end
          end else if (done_reg) begin
            bitn_reg <= bitn_reg + 4'h1;
            if (dir_reg == `DIR_WRITE)
              sh_reg <= {sh_reg[6:0], 1'b0};
            else
              sh_reg <= {sh_reg[6:0], samp_reg};
            if (dir_reg && bitn_reg == 4'h7) begin
              push_reg      <= 1'b1;
              push_data_reg <= {ptr_reg + {{(AW-CW){1'b0}}, cnt_reg},
                                sh_reg[6:0], samp_reg};
            end
            if (bitn_reg[3]) begin
              bitn_reg <= 4'h0;
              cnt_reg  <= cnt_inc;
              st_reg   <= S_BOUND;
              if (last_rx)
                end_reg <= 1'b1;
              if (!dir_reg && samp_reg == `BIT_NACK) begin
                evt_reg[`EVT_ERROR] <= 1'b1;
                end_reg <= 1'b1;
              end
              if (dir_reg && !last_rx && cnt_inc + 1'b1 == max_reg)
                evt_reg[`EVT_FINAL_RX] <= 1'b1;
            end
          end
        end
        S_HOLD: begin
          if (start_pend_reg) begin
            st_reg <= S_START;
          end else if (stop_pend_reg) begin
            st_reg        <= S_STOP;
            stop_pend_reg <= 1'b0;
          end
        end
        S_SUSP: begin
          if (task_resume_i)
            st_reg <= S_BOUND;
        end
        S_STOP: begin
          if (!busy_reg && !issued_reg && !go_reg) begin
            issued_reg <= 1'b1;
            go_reg     <= 1'b1;
            go_a_reg   <= 1'b0;
            go_b_reg   <= 1'b1;
          end else if (done_reg) begin
            st_reg <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          stop_pend_reg <= 1'b0;
          if (fifo_empty && !push_reg && !txreq_reg) begin
            st_reg <= S_IDLE;
            evt_reg[`EVT_STOPPED] <= 1'b1;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Sticky flags; a set in the clearing cycle wins
  // -------------------------------------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      flags_reg <= `EVT_RESET;
    else
      flags_reg <= (flags_reg & ~evt_clear_i) | evt_reg;
  end

  assign evt_pulse_o  = evt_reg;
  assign evt_flags_o  = flags_reg;
  assign irq_o        = |(flags_reg & evt_inten_i);
  assign tx_rd_req_o  = txreq_reg;
  assign tx_rd_addr_o = txaddr_reg;
  assign rx_wr_addr_o = fifo_out[AW+7:8];
  assign rx_wr_data_o = fifo_out[7:0];
  assign scl_o        = 1'b0;
  assign sda_o        = 1'b0;
  assign scl_oe_o     = scl_oe_reg;
  assign sda_oe_o     = sda_oe_reg;
  assign busy_o       = ~st_reg[0];

endmodule // two_wire_master_dma

// file: verilog/two_wire_master_dma_regs.vh
/*
  Constants for the two-wire bus master with memory access: event bit
  positions, rate codes, bus timing and reset values.
  Assumes a 250 MHz system clock; included by its bare name.
*/
// Contract
// - Start tasks begin a transfer; stop task halts it, then stopped event fires.
// - Suspend task enters suspended state, fires event, holds SCL low until resume.
// - Suspend waits for the current byte; ignored when no transfer is active.
// - A not-acknowledge from the slave raises the error event.
// - Wait while a slave holds SCL low before timing the high phase.
// - Bus rates of 100, 250 and 400 kbit/s are selectable.
// - Sole master on the bus; no arbitration logic.
// - Seven-bit slave address follows the start condition; no CBUS.
// - Pointers and counts are captured at start; software reloads after started event.
// - Stopped event waits until all memory traffic is finished.
// - Write start sends address with direction 0 and samples acknowledge.
// - Write bytes are fetched from the tx pointer and sent, each acknowledged.
// - Final-tx-byte event fires when the last write byte begins.
// - Never stop alone at buffer end or error; hold bus until stop task.
// - Read start sends direction 1; bytes stored, all acked but last is nacked.
// - Final-rx event after previous byte ack, or after address ack when count is 1.
// - Repeated start chains write and read without a stop condition.
`ifndef TWO_WIRE_MASTER_DMA_REGS_VH
`define TWO_WIRE_MASTER_DMA_REGS_VH

// ---------------------------------------------------------------------
// Event bit positions
// ---------------------------------------------------------------------
`define EVT_COUNT            7
`define EVT_STOPPED          0
`define EVT_ERROR            1
`define EVT_SUSPENDED        2
`define EVT_RX_STARTED       3
`define EVT_TX_STARTED       4
`define EVT_FINAL_RX         5
`define EVT_FINAL_TX         6
`define EVT_RESET            7'h00

// ---------------------------------------------------------------------
// Rate selection and timing
// ---------------------------------------------------------------------
`define RATE_100K            2'h0
`define RATE_250K            2'h1
`define RATE_400K            2'h2
`define CLK_PERIOD_NS        4
`define BIT_100K_NS          10000
`define BIT_250K_NS          4000
`define BIT_400K_NS          2500
// Quarter bit in cycles, rounded up so the rate never exceeds its figure
`define QUARTER_CYC(t)       (((t) + 4 * `CLK_PERIOD_NS - 1) / \
                              (4 * `CLK_PERIOD_NS))

// ---------------------------------------------------------------------
// Bus levels
// ---------------------------------------------------------------------
`define DIR_WRITE            1'b0
`define DIR_READ             1'b1
`define BIT_ACK              1'b0
`define BIT_NACK             1'b1
`define LINE_IDLE            1'b1

`endif

// file: verilog/pin_sync.v
/*
  Three-stage input synchroniser with agreement filter.
  Assumes an asynchronous input; the output moves only when stages two
  and three agree.
*/
`timescale 1ns/1ps

module pin_sync #(
  parameter INIT = 1'b1
) (
  input  wire mclk_i,      // System clock
  input  wire reset_n_i,   // Async reset, active low
  input  wire async_i,     // Raw pin level
  output wire sync_o       // Filtered level
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg out_reg;

  // -------------------------------------------------------------------
  // Stages; stage one feeds only stage two to keep metastability out
  // -------------------------------------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_reg  <= INIT;
      s2_reg  <= INIT;
      s3_reg  <= INIT;
      out_reg <= INIT;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        out_reg <= s3_reg;
    end
  end

  assign sync_o = out_reg;

endmodule // pin_sync

// file: verilog/sync_fifo.v
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and PW is its log2.
*/
`timescale 1ns/1ps

module sync_fifo #(
  parameter W     = 40,
  parameter DEPTH = 16,
  parameter PW    = 4
) (
  input  wire         mclk_i,     // System clock
  input  wire         reset_n_i,  // Async reset, active low
  input  wire         in_valid_i, // Write request
  output wire         in_ready_o, // Room available
  input  wire [W-1:0] in_data_i,  // Write data
  output wire         out_valid_o,// Data available
  input  wire         out_ready_i,// Consumer takes word
  output wire [W-1:0] out_data_o, // Head word
  output wire         empty_o     // Nothing stored
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [PW:0]  wr_reg;
  reg [PW:0]  rd_reg;
  wire        full;
  wire        empty;
  wire        push;
  wire        pop;

  // -------------------------------------------------------------------
  // Flags from pointers with a wrap bit
  // -------------------------------------------------------------------
  assign full  = (wr_reg[PW] != rd_reg[PW]) &&
                 (wr_reg[PW-1:0] == rd_reg[PW-1:0]);
  assign empty = (wr_reg == rd_reg);
  assign push  = in_valid_i & ~full;
  assign pop   = out_ready_i & ~empty;

  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign empty_o     = empty;
  assign out_data_o  = mem[rd_reg[PW-1:0]];

  // Storage has no reset; it is only read behind a valid pointer
  always @(posedge mclk_i) begin
    if (push)
      mem[wr_reg[PW-1:0]] <= in_data_i;
  end

  // Pointer advance
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_reg <= {(PW+1){1'b0}};
      rd_reg <= {(PW+1){1'b0}};
    end else begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
    end
  end

endmodule // sync_fifo

// file: testbench/twm_properties.sv
/* Port checker for two_wire_master_dma.
   Assumes it is bound onto the top module and sees only its ports. */
`timescale 1ns/1ps
module twm_props #(parameter AW = 32) (
  input wire mclk_i, reset_n_i, task_begin_write_i, task_begin_read_i,
  input wire task_suspend_i, irq_o, tx_rd_req_o, tx_rd_ack_i, busy_o,
  input wire rx_wr_valid_o, rx_wr_ready_i, scl_oe_o, sda_oe_o,
  input wire [6:0] evt_pulse_o, evt_flags_o, evt_inten_i,
  input wire [AW-1:0] tx_rd_addr_o,
  input wire [7:0] rx_wr_data_o);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Start answers, stop ordering and idle lines
  property p_wr_go; task_begin_write_i && !task_begin_read_i && !busy_o
    |-> ##3 evt_pulse_o[4]; endproperty
  a_wr_go: assert property (p_wr_go) else $error("no tx start");
  property p_rd_go; task_begin_read_i && !busy_o |-> ##3 evt_pulse_o[3];
  endproperty
  a_rd_go: assert property (p_rd_go) else $error("no rx start");
  property p_stop; evt_pulse_o[0] |-> !tx_rd_req_o && !rx_wr_valid_o;
  endproperty
  a_stop: assert property (p_stop) else $error("memory busy");
  property p_idle; !busy_o ##1 !busy_o |-> !scl_oe_o && !sda_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("line driven");
  // Suspension holds the clock low; ignored while idle
  property p_susp; evt_pulse_o[2] |-> ##2 scl_oe_o [*8]; endproperty
  a_susp: assert property (p_susp) else $error("scl freed");
  property p_isus; task_suspend_i && !busy_o |=> !evt_pulse_o[2] [*3];
  endproperty
  a_isus: assert property (p_isus) else $error("idle suspend");
  // Flags hold events; the request line follows them
  property p_flag; |evt_pulse_o |=>
    (evt_flags_o & $past(evt_pulse_o)) == $past(evt_pulse_o); endproperty
  a_flag: assert property (p_flag) else $error("flag lost");
  property p_irq; irq_o == |(evt_flags_o & evt_inten_i); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  // Memory requests stand until answered
  property p_req; tx_rd_req_o && !tx_rd_ack_i |=>
    tx_rd_req_o && $stable(tx_rd_addr_o); endproperty
  a_req: assert property (p_req) else $error("req dropped");
  property p_wr; rx_wr_valid_o && !rx_wr_ready_i |=>
    rx_wr_valid_o && $stable(rx_wr_data_o); endproperty
  a_wr: assert property (p_wr) else $error("write dropped");
  c_ftx: cover property (evt_pulse_o[6]);
  c_frx: cover property (evt_pulse_o[5]);
  c_err: cover property (evt_pulse_o[1]);
endmodule // twm_props
bind two_wire_master_dma twm_props #(.AW(AW)) twm_props_i (.*);

// file: testbench/slave_model.sv
/* Behavioural slave on the open-drain pair.
   Assumes resolved line levels with pull-ups from the bench. */
`timescale 1ns/1ps
module slave_model #(parameter [6:0] ADDR = 7'h2a) (
  input  wire scl_i,  // Resolved clock line
  input  wire sda_i,  // Resolved data line
  input  wire nack_i, // Refuse every byte
  output reg  pull_o  // Pull data line low
);
  reg [7:0] sh, tx, last;
  reg [3:0] n;
  reg       act, first, rd;
  initial begin
    pull_o = 0; act = 0; tx = 8'ha5;
  end
  // Start and stop are data edges while the clock is high
  always @(sda_i) if (scl_i === 1'b1) begin
    act = !sda_i; n = 0; first = 1; rd = 0; pull_o = 0;
  end
  // Shift on the rising clock; a master nack ends the read
  always @(posedge scl_i) if (act) begin
    if (n == 8 && rd && !first && sda_i) rd = 0;
    sh = {sh[6:0], sda_i};
    n = n + 1;
  end
  // Change data only while the clock is low
  always @(negedge scl_i) if (act) begin
    if (n == 9) begin
      if (rd && !first) tx = tx + 8'h01;
      n = 0; first = 0;
    end
    if (n == 8) begin
      if (first) rd = sh[0];
      else last = sh;
      pull_o = !nack_i && (first ? sh[7:1] == ADDR : !rd);
    end else
      pull_o = rd && !first && !tx[3'd7 - n[2:0]];
  end
endmodule // slave_model

// file: testbench/tb_top.sv
/* Self-checking bench for two_wire_master_dma with a slave model.
   Assumes design, checker and slave model are compiled first. */
`timescale 1ns/1ps
module tb_top;
  reg mclk_i = 0, reset_n_i = 0, task_begin_write_i = 0, nack = 0;
  reg task_begin_read_i = 0, task_stop_i = 0, task_suspend_i = 0;
  reg task_resume_i = 0, tx_rd_ack_i = 0, rx_wr_ready_i = 1, man_stop = 0;
  reg [6:0] evt_clear_i = 0, evt_inten_i = 7'h02;
  reg [7:0] tx_rd_data_i = 0, got [0:1];
  reg [15:0] tx_max_count_i = 16'h2, rx_max_count_i = 16'h2;
  reg [1:0] rate_sel_i = 2'h2; // 400k keeps bytes short
  wire [6:0] slave_addr_i = 7'h2a, evt_pulse_o, evt_flags_o;
  wire [31:0] tx_buffer_pointer_i = 32'h1c3, rx_buffer_pointer_i = 32'h200;
  wire [31:0] tx_rd_addr_o, rx_wr_addr_o;
  wire [7:0] rx_wr_data_o;
  wire irq_o, tx_rd_req_o, rx_wr_valid_o, scl_o, sda_o, busy_o, pull;
  wire scl_oe_o, sda_oe_o;
  wire scl_i = !scl_oe_o;
  wire sda_i = !(sda_oe_o || pull);
  integer num_errors = 0, cmp_count = 0, nrx = 0;
  two_wire_master_dma two_wire_master_dma_i (.*);
  slave_model slave_model_i (.scl_i(scl_i), .sda_i(sda_i), .nack_i(nack),
    .pull_o(pull));
  always #2 mclk_i = !mclk_i;
  // Memory answers a cycle late; final events link to stop
  always @(posedge mclk_i) begin
    tx_rd_ack_i <= tx_rd_req_o && !tx_rd_ack_i;
    tx_rd_data_i <= tx_rd_addr_o[7:0];
    task_stop_i <= |evt_pulse_o[6:5] || man_stop;
    if (rx_wr_valid_o && rx_wr_ready_i) begin
      got[nrx[0]] <= rx_wr_data_o ^ rx_wr_addr_o[7:0]; // Address folded in
      nrx <= nrx + 1;
    end
  end
  task chk(input string nm, input [31:0] seen, exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait for an event pulse, then one edge for its flag
  task wt(input integer b);
    integer k;
    for (k = 0; evt_pulse_o[b] !== 1'b1 && k < 30000; k = k + 1)
      @(posedge mclk_i);
    if (k == 30000) num_errors = num_errors + 1;
    @(posedge mclk_i);
  endtask
  task t_write;
    task_begin_write_i <= 1;
    @(posedge mclk_i) task_begin_write_i <= 0;
    wt(4);
    task_suspend_i <= 1;
    @(posedge mclk_i) task_suspend_i <= 0;
    wt(2);
    chk("scl held", scl_i, 0);
    repeat (400) @(posedge mclk_i);
    task_resume_i <= 1;
    @(posedge mclk_i) task_resume_i <= 0;
    wt(0);
    chk("write flags", evt_flags_o, 7'h55);
    chk("last byte", slave_model_i.last, 8'hc4);
    chk("idle", {busy_o, irq_o, scl_o, sda_o}, 0);
  endtask
  task t_read;
    evt_clear_i <= 7'h7f;
    rx_wr_ready_i <= 0;
    @(posedge mclk_i) evt_clear_i <= 0;
    task_begin_read_i <= 1;
    @(posedge mclk_i) task_begin_read_i <= 0;
    wt(5);
    rx_wr_ready_i <= 1;
    wt(0);
    chk("rx byte0", got[0], 8'ha5 ^ 8'h00);
    chk("rx byte1", got[1], 8'ha6 ^ 8'h01);
    chk("read flags", evt_flags_o, 7'h29);
  endtask
  task t_nack_idle;
    evt_clear_i <= 7'h7f;
    nack <= 1;
    rate_sel_i <= 2'h1;
    @(posedge mclk_i) evt_clear_i <= 0;
    task_begin_write_i <= 1;
    @(posedge mclk_i) task_begin_write_i <= 0;
    wt(1);
    repeat (2000) @(posedge mclk_i);
    chk("held", {busy_o, scl_i, irq_o}, 3'b101);
    man_stop <= 1;
    @(posedge mclk_i) man_stop <= 0;
    wt(0);
    chk("error flag", evt_flags_o[1], 1);
    task_suspend_i <= 1;
    @(posedge mclk_i) task_suspend_i <= 0;
    repeat (8) @(posedge mclk_i);
    chk("idle suspend", evt_flags_o[2], 0);
  endtask
  task end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Cut a hang short well past the expected run
  initial begin
    repeat (90000) @(posedge mclk_i);
    num_errors = num_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1;
    repeat (6) @(posedge mclk_i);
    t_write;
    t_read;
    t_nack_idle;
    end_of_test;
  end
endmodule // tb_top
